// ===== hdl/mic_ctrl.sv
// interrupt controller: flags, enables, arbitration, vectoring and wake-up
`timescale 1ns/1ps
`default_nettype none

module mic_ctrl
    import mic_pkg::*;
(
    input wire logic mclk,                 // system clock
    input wire logic nrst,                 // async reset, active low
    input wire logic [4:0] address,        // avalon byte address
    input wire logic read,                 // avalon read
    input wire logic write,                // avalon write
    input wire logic [31:0] writedata,     // avalon write data
    input wire logic [3:0] byteenable,     // avalon byte lanes
    output logic [31:0] readdata,          // avalon read data
    output logic waitrequest,              // avalon wait
    input wire logic ext_pin_a,            // external pin a level
    input wire logic ext_pin_b_main,       // external pin b, default source
    input wire logic ext_pin_b_alt,        // external pin b, alternate source
    input wire logic pin_a_is_input,       // port direction of pin a
    input wire logic pin_b_is_input,       // port direction of pin b
    input wire logic pull_a_sel,           // pull-high choice, pin a
    input wire logic pull_b_sel,           // pull-high choice, pin b
    output logic pull_a_en,                // pull-high drive, pin a
    output logic pull_b_en,                // pull-high drive, pin b
    input wire mic_events_s events,        // peripheral event pulses
    input wire logic core_ready,           // core at instruction boundary
    input wire logic stack_full,           // core stack has no room
    input wire logic return_from_irq,                 // return_from_irq executed
    output logic irq_pending,              // enabled request waiting
    output logic irq_take,                 // push pc and load vector
    output logic [11:0] vector_addr,       // vector to load
    output logic stack_pop,                // pop saved pc
    output logic wake                      // wake-up pulse
);

    // ****************************************
    // helper functions
    // ****************************************

    // highest-priority set bit, lowest index wins
    function automatic logic [2:0] first_set(input logic [7:0] req);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = 7; i >= 0; i--)
        begin
            if (req[i])
            begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction : first_set

    // vector address of a source
    function automatic logic [11:0] vec_of(input logic [2:0] idx);
        return 12'(VEC_BASE + VEC_STEP * {9'h000, idx});
    endfunction : vec_of

    // ****************************************
    // state
    // ****************************************

    logic [3:0] edge_sel;           // {ext_b_edge_sel, ext_a_edge_sel}
    logic global_irq_enable;
    logic [7:0] src_en;             // indexed by source rank
    logic [7:0] src_flag;           // indexed by source rank
    logic [3:0] mem_en;             // {p_a, p_p, s_a, s_p} compare enables
    logic [3:0] mem_flag;           // {p_a, p_p, s_a, s_p} compare flags
    logic input_source_select;
    logic [7:0] next_flag;
    logic [3:0] next_mem;
    logic [7:0] flag_set;
    logic [3:0] mem_set;
    logic [1:0] grp_set;
    logic [1:0] pin_edge;
    logic [7:0] pend;
    logic [2:0] win;
    logic take_now;
    mic_state_e state;
    logic ack;
    logic wr_go;
    logic [7:0] wd;

    // ****************************************
    // avalon slave
    // ****************************************

    // one wait cycle on every access
    assign waitrequest = (read | write) & ~ack;
    assign wr_go = write & ack & byteenable[0];
    assign wd = writedata[7:0];

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            ack <= 1'b0;
        else
            ack <= (read | write) & ~ack;
    end

    // read data latched in the wait cycle, stands at the ack edge
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            readdata <= 32'h0000_0000;
        else if (read & ~ack)
        begin
            case (address)
                REG_EDGE: readdata <= {28'h0000000, edge_sel};
                REG_PRIM: readdata <= {25'h0000000, src_flag[SRC_GRP1], src_flag[SRC_GRP0],
                    src_flag[SRC_EXT_A], src_en[SRC_GRP1], src_en[SRC_GRP0],
                    src_en[SRC_EXT_A], global_irq_enable};
                REG_SEC: readdata <= {24'h000000, src_flag[SRC_TICK1], src_flag[SRC_TICK0],
                    src_flag[SRC_EEPROM], src_flag[SRC_CONV], src_en[SRC_TICK1],
                    src_en[SRC_TICK0], src_en[SRC_EEPROM], src_en[SRC_CONV]};
                REG_EXTB: readdata <= {27'h0000000, src_flag[SRC_EXT_B], 3'h0, src_en[SRC_EXT_B]};
                REG_GRP0: readdata <= {26'h0000000, mem_flag[1:0], 2'h0, mem_en[1:0]};
                REG_GRP1: readdata <= {26'h0000000, mem_flag[3:2], 2'h0, mem_en[3:2]};
                REG_SRC: readdata <= {31'h00000000, input_source_select};
                default: readdata <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // control registers
    // ****************************************

    // edge selects, enables, source select
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            edge_sel <= REG_RESET[3:0];
            src_en <= REG_RESET;
            mem_en <= REG_RESET[3:0];
            input_source_select <= 1'b0;
        end
        else if (wr_go)
        begin
            case (address)
                REG_EDGE: edge_sel <= wd[3:0];
                REG_PRIM: src_en[2:0] <= wd[3:1];
                REG_SEC: src_en[6:3] <= {wd[3], wd[2], wd[1], wd[0]};
                REG_EXTB: src_en[SRC_EXT_B] <= wd[EN_LSB];
                REG_GRP0: mem_en[1:0] <= wd[1:0];
                REG_GRP1: mem_en[3:2] <= wd[1:0];
                REG_SRC: input_source_select <= wd[SRC_SEL_BIT];
                default: edge_sel <= edge_sel;
            endcase
        end
    end

    // global enable, cleared by hardware on every take
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            global_irq_enable <= 1'b0;
        else if (take_now)
            global_irq_enable <= 1'b0;
        else if (wr_go && address == REG_PRIM)
            global_irq_enable <= wd[PRIM_GLOBAL];
    end

    // ****************************************
    // external pins
    // ****************************************

    // pull-high stays as selected in any pin use
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            pull_a_en <= 1'b0;
            pull_b_en <= 1'b0;
        end
        else
        begin
            pull_a_en <= pull_a_sel;
            pull_b_en <= pull_b_sel;
        end
    end

    logic [1:0] pin_raw;
    logic [1:0] pin_ok;
    assign pin_raw = {input_source_select ? ext_pin_b_alt : ext_pin_b_main, ext_pin_a};
    assign pin_ok = {src_en[SRC_EXT_B] & pin_b_is_input,
                     src_en[SRC_EXT_A] & pin_a_is_input};

    // two-stage synchroniser plus history stage per pin
    genvar gp;
    generate
        for (gp = 0; gp < 2; gp++)
        begin : g_pin
            logic s1;
            logic s2;
            logic s3;
            logic [1:0] sel;
            assign sel = edge_sel[2*gp +: 2];
            always_ff @(posedge mclk or negedge nrst)
            begin
                if (!nrst)
                begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                end
                else
                begin
                    s1 <= pin_raw[gp];
                    s2 <= s1;
                    s3 <= s2;
                end
            end
            // qualifying transition
            assign pin_edge[gp] = pin_ok[gp] &&
                (((sel == EDGE_RISE || sel == EDGE_BOTH) && s2 && !s3) ||
                 ((sel == EDGE_FALL || sel == EDGE_BOTH) && !s2 && s3));
        end
    endgenerate

    // ****************************************
    // request flags
    // ****************************************

    // member compare flags: set wins, never cleared by service
    always_comb
    begin
        mem_set = {events.p_cmp_a, events.p_cmp_p, events.s_cmp_a, events.s_cmp_p};
        next_mem = mem_flag;
        if (wr_go && address == REG_GRP0)
            next_mem[1:0] = wd[5:4];
        if (wr_go && address == REG_GRP1)
            next_mem[3:2] = wd[5:4];
        next_mem = next_mem | mem_set;
    end

    // a group flag follows any member flag rising
    assign grp_set = {|(next_mem[3:2] & ~mem_flag[3:2]),
                      |(next_mem[1:0] & ~mem_flag[1:0])};

    assign flag_set = {pin_edge[1], events.tick1, events.tick0, events.eeprom_done,
                       events.conv_done, grp_set, pin_edge[0]};

    // source flags: software write, service clear, then set on top
    always_comb
    begin
        next_flag = src_flag;
        if (wr_go && address == REG_PRIM)
            next_flag[2:0] = wd[6:4];
        if (wr_go && address == REG_SEC)
            next_flag[6:3] = {wd[7], wd[6], wd[5], wd[4]};
        if (wr_go && address == REG_EXTB)
            next_flag[SRC_EXT_B] = wd[FLAG_LSB];
        if (take_now)
            next_flag[win] = 1'b0;
        next_flag = next_flag | flag_set;
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            src_flag <= REG_RESET;
            mem_flag <= REG_RESET[3:0];
        end
        else
        begin
            src_flag <= next_flag;
            mem_flag <= next_mem;
        end
    end

    // wake on any flag rising, enables ignored
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            wake <= 1'b0;
        else
            wake <= |(next_flag & ~src_flag) | |(next_mem & ~mem_flag);
    end

    // ****************************************
    // arbitration and vectoring
    // ****************************************

    // pending: flag and enable; groups need an enabled member too
    always_comb
    begin
        pend = src_flag & src_en;
        pend[SRC_GRP0] = pend[SRC_GRP0] & |(mem_flag[1:0] & mem_en[1:0]);
        pend[SRC_GRP1] = pend[SRC_GRP1] & |(mem_flag[3:2] & mem_en[3:2]);
    end

    assign win = first_set(pend);
    assign irq_pending = global_irq_enable & |pend;
    assign take_now = (state == ST_RUN) && core_ready && irq_pending
        && !stack_full;

    // take state: one cycle of push and vector load
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            state <= ST_RUN;
        else
        begin
            case (state)
                ST_RUN: state <= take_now ? ST_VECTOR : ST_RUN;
                ST_VECTOR: state <= ST_RUN;
                default: state <= ST_RUN;
            endcase
        end
    end

    assign irq_take = (state == ST_VECTOR);

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            vector_addr <= 12'h000;
        else if (take_now)
            vector_addr <= vec_of(win);
    end

    // return from handler pops the saved pc
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            stack_pop <= 1'b0;
        else
            stack_pop <= return_from_irq;
    end

    // ****************************************
    // assertions
    // ****************************************

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    property p_pin_edge_sets;
        pin_edge[1] |=> src_flag[SRC_EXT_B];
    endproperty
    a_pin_edge_sets: assert property (p_pin_edge_sets) else $error("pin edge lost");

    property p_edge_off_quiet;
        (edge_sel[1:0] == EDGE_OFF) |-> !pin_edge[0];
    endproperty
    a_edge_off_quiet: assert property (p_edge_off_quiet)
        else $error("disabled edge fired");

    property p_event_sets;
        events.conv_done |=> src_flag[SRC_CONV];
    endproperty
    a_event_sets: assert property (p_event_sets) else $error("event flag missed");

    property p_disabled_holds;
        (src_flag[SRC_CONV] && !src_en[SRC_CONV] && !(wr_go && address == REG_SEC))
            |=> src_flag[SRC_CONV];
    endproperty
    a_disabled_holds: assert property (p_disabled_holds) else $error("flag dropped");

    property p_no_global_no_take;
        (!global_irq_enable && state == ST_RUN) |=> !irq_take;
    endproperty
    a_no_global_no_take: assert property (p_no_global_no_take)
        else $error("take w/o global");

    property p_take_vector;
        take_now |=> irq_take && vector_addr == vec_of($past(win)) && !global_irq_enable;
    endproperty
    a_take_vector: assert property (p_take_vector) else $error("bad vector or global");

    property p_return_from_irq_pop;
        return_from_irq |=> stack_pop ##1 ($past(return_from_irq) || !stack_pop);
    endproperty
    a_return_from_irq_pop: assert property (p_return_from_irq_pop) else $error("pop missing");

    property p_full_blocks;
        (state == ST_RUN && stack_full) |=> !irq_take;
    endproperty
    a_full_blocks: assert property (p_full_blocks) else $error("take on full stack");

    property p_wake_on_rise;
        $rose(src_flag[SRC_TICK0]) |-> wake;
    endproperty
    a_wake_on_rise: assert property (p_wake_on_rise) else $error("no wake");

    property p_group_set;
        (next_mem[1:0] & ~mem_flag[1:0]) != 2'h0 |=> src_flag[SRC_GRP0];
    endproperty
    a_group_set: assert property (p_group_set) else $error("group flag missed");

    property p_group_keeps_members;
        (take_now && win == SRC_GRP0)
            |=> (mem_flag[1:0] & $past(mem_flag[1:0])) == $past(mem_flag[1:0]);
    endproperty
    a_group_keeps_members: assert property (p_group_keeps_members)
        else $error("member lost");

    property p_service_clears;
        (take_now && win == SRC_EEPROM && !events.eeprom_done) |=> !src_flag[SRC_EEPROM];
    endproperty
    a_service_clears: assert property (p_service_clears) else $error("flag kept");

    c_take_ext_a: cover property (take_now && win == SRC_EXT_A);
    c_take_group1: cover property (take_now && win == SRC_GRP1);
    c_full_wait: cover property (stack_full && irq_pending ##1 !stack_full ##1 irq_take);
    c_wake: cover property (wake && !global_irq_enable);

endmodule : mic_ctrl

`default_nettype wire

// ===== pkg/mic_pkg.sv
// constants, types and register map of the interrupt controller
//
// Function
// - ext_b_edge_sel picks trigger: 00 off, 01 rising, 10 falling, 11 both.
// - ext_a_edge_sel uses the same encoding; both fields reset to zero.
// - a source event sets that source's request flag.
// - a set flag with its enable low stays set but never vectors.
// - with global_irq_enable low no interrupt is taken at all.
// - taking an interrupt pushes the next address and loads the source vector.
// - return_from_irq pops the saved program counter so execution resumes.
// - servicing any interrupt clears global_irq_enable, blocking nesting.
// - requests arriving while global enable is low still set their flags.
// - while the stack is full no enabled request is acknowledged.
// - any flag rising wakes from sleep or idle; pre-set flags never wake.
// - a pin flag sets on the transition its edge field selects.
// - a shared pin acts as interrupt input only when enabled and an input.
// - servicing a pin interrupt clears its flag and the global enable.
// - pin pull-high selection stays in effect in interrupt use.
// - the source of external pin b is chosen by input_source_select.
// - two group interrupts, each from one timer's compare a and p matches.
// - a group flag sets whenever one of its member flags sets.
// - enabled group with a member request vectors to the shared group vector.
// - group service clears only group flag and global enable, members stay.
// - a comparator vectors only with global, its own and group enables set.
// - wake-up from a rising flag ignores all enable bits.
// - converter, tick and eeprom service clear their own flag too.
package mic_pkg;

    // register byte addresses, one aligned word each
    localparam logic [4:0] REG_EDGE = 5'h00;
    localparam logic [4:0] REG_PRIM = 5'h04;
    localparam logic [4:0] REG_SEC = 5'h08;
    localparam logic [4:0] REG_EXTB = 5'h0c;
    localparam logic [4:0] REG_GRP0 = 5'h10;
    localparam logic [4:0] REG_GRP1 = 5'h14;
    localparam logic [4:0] REG_SRC = 5'h18;
    localparam logic [7:0] REG_RESET = 8'h00;

    // field positions
    localparam int EDGE_A_LSB = 0;
    localparam int EDGE_B_LSB = 2;
    localparam int PRIM_GLOBAL = 0;
    localparam int EN_LSB = 0;
    localparam int FLAG_LSB = 4;
    localparam int SRC_SEL_BIT = 0;

    // edge-select encoding
    localparam logic [1:0] EDGE_OFF = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // source index = priority rank, 0 highest
    localparam logic [2:0] SRC_EXT_A = 3'h0;
    localparam logic [2:0] SRC_GRP0 = 3'h1;
    localparam logic [2:0] SRC_GRP1 = 3'h2;
    localparam logic [2:0] SRC_CONV = 3'h3;
    localparam logic [2:0] SRC_EEPROM = 3'h4;
    localparam logic [2:0] SRC_TICK0 = 3'h5;
    localparam logic [2:0] SRC_TICK1 = 3'h6;
    localparam logic [2:0] SRC_EXT_B = 3'h7;

    // program vector addresses
    localparam logic [11:0] VEC_BASE = 12'h004;
    localparam logic [11:0] VEC_STEP = 12'h004;

    // peripheral event pulses
    typedef struct packed {
        logic tick0;
        logic tick1;
        logic eeprom_done;
        logic conv_done;
        logic s_cmp_a;
        logic s_cmp_p;
        logic p_cmp_a;
        logic p_cmp_p;
    } mic_events_s;

    typedef enum logic [0:0] {
        ST_RUN = 1'b0,
        ST_VECTOR = 1'b1
    } mic_state_e;

endpackage : mic_pkg

// ===== verification/mic_core_model.sv
// behavioural model of the core sequencer and its return stack
`timescale 1ns/1ps
`default_nettype none

module mic_core_model
    import mic_pkg::*;
#(
    parameter int DEPTH = 1
)
(
    input wire logic mclk,       // system clock
    input wire logic nrst,       // async reset, active low
    input wire logic irq_take,   // push from controller
    input wire logic stack_pop,  // pop from controller
    input wire logic ret_req,    // bench asks for a return
    output logic core_ready,     // always at a boundary
    output logic stack_full,     // no room for a push
    output logic return_from_irq            // return pulse
);
    logic [3:0] depth;
    // push on take, pop on return
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            depth <= 4'h0;
        else if (irq_take)
            depth <= depth + 4'h1;
        else if (stack_pop)
            depth <= depth - 4'h1;
    end
    // a full stack holds the controller off
    assign stack_full = (depth == 4'(DEPTH));
    assign core_ready = 1'b1;
    // return only with something stacked
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            return_from_irq <= 1'b0;
        else
            return_from_irq <= ret_req && (depth != 4'h0);
    end
endmodule : mic_core_model
`default_nettype wire

// ===== verification/testbench.sv
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import mic_pkg::*;
    // ****
    // setup
    // ****
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [4:0] address = 5'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic pin_a = 1'b0;
    logic pin_b_alt = 1'b0;
    logic pin_b_main = 1'b0;
    logic pin_a_in = 1'b1;
    logic pull_a = 1'b0;
    logic pull_b = 1'b0;
    logic ret_req = 1'b0;
    mic_events_s events = '0;
    logic [31:0] readdata;
    logic [11:0] vector_addr;
    logic waitrequest, pull_a_en, pull_b_en, core_ready, stack_full, return_from_irq;
    logic irq_pending, irq_take, stack_pop, wake;
    int failures = 0;
    int compares = 0;

    // clock source
    initial forever #10 mclk = ~mclk;

    mic_ctrl dut (.mclk(mclk), .nrst(nrst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(4'hf), .readdata(readdata),
        .waitrequest(waitrequest), .ext_pin_a(pin_a), .ext_pin_b_main(pin_b_main),
        .ext_pin_b_alt(pin_b_alt), .pin_a_is_input(pin_a_in), .pin_b_is_input(1'b1),
        .pull_a_sel(pull_a), .pull_b_sel(pull_b), .pull_a_en(pull_a_en),
        .pull_b_en(pull_b_en), .events(events), .core_ready(core_ready),
        .stack_full(stack_full), .return_from_irq(return_from_irq), .irq_pending(irq_pending),
        .irq_take(irq_take), .vector_addr(vector_addr), .stack_pop(stack_pop), .wake(wake));
    mic_core_model #(.DEPTH(1)) core (.mclk(mclk), .nrst(nrst), .irq_take(irq_take),
        .stack_pop(stack_pop), .ret_req(ret_req), .core_ready(core_ready),
        .stack_full(stack_full), .return_from_irq(return_from_irq));

    // ****
    // helpers
    // ****
    function automatic logic [11:0] vec(input logic [2:0] r);
        return VEC_BASE + VEC_STEP * {9'h0, r};
    endfunction : vec

    task chk(input logic [11:0] got, input logic [11:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task bw(input logic [4:0] a, input logic [7:0] d);
        @(posedge mclk);
        address <= a;
        writedata <= {24'h0, d};
        write <= 1'b1;
        do @(posedge mclk); while (waitrequest !== 1'b0);
        write <= 1'b0;
    endtask : bw

    task rd_chk(input logic [4:0] a, input logic [7:0] exp);
        @(posedge mclk);
        address <= a;
        read <= 1'b1;
        do @(posedge mclk); while (waitrequest !== 1'b0);
        read <= 1'b0;
        chk(readdata[11:0], {4'h0, exp});
    endtask : rd_chk

    task pulse(input logic [7:0] ev, input logic exp_wake);
        logic w;
        w = 1'b0;
        @(posedge mclk) events <= mic_events_s'(ev);
        @(posedge mclk) events <= '0;
        repeat (4)
        begin
            @(posedge mclk);
            w = w | wake;
        end
        chk({11'h0, w}, {11'h0, exp_wake});
    endtask : pulse

    task see_take(input logic [11:0] exp);
        logic [11:0] v;
        v = 12'hfff;
        repeat (8)
        begin
            @(posedge mclk);
            if (irq_take === 1'b1 && v === 12'hfff)
                v = vector_addr;
        end
        chk(v, exp);
    endtask : see_take

    task do_ret;
        logic p;
        p = 1'b0;
        @(posedge mclk) ret_req <= 1'b1;
        @(posedge mclk) ret_req <= 1'b0;
        for (int i = 0; i < 4 && p !== 1'b1; i++)
        begin
            @(posedge mclk);
            p = stack_pop;
        end
        chk({11'h0, p}, 12'h001);
    endtask : do_ret

    task close_out;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : close_out

    // ****
    // scenarios
    // ****
    task t_edges;
        for (int i = 0; i < 8; i++) rd_chk(5'(i * 4), 8'h00);
        for (int m = 0; m < 4; m++)
        begin
            bw(REG_EDGE, 8'(m));
            bw(REG_PRIM, 8'h02);
            @(posedge mclk) pin_a <= 1'b1;
            repeat (6) @(posedge mclk);
            rd_chk(REG_PRIM, {3'h0, m[0], 4'h2});
            bw(REG_PRIM, 8'h02);
            @(posedge mclk) pin_a <= 1'b0;
            repeat (6) @(posedge mclk);
            rd_chk(REG_PRIM, {3'h0, m[1], 4'h2});
        end
        bw(REG_PRIM, 8'h02);
        @(posedge mclk);
        pin_a_in <= 1'b0;
        pin_a <= 1'b1;
        pull_a <= 1'b1;
        pull_b <= 1'b1;
        repeat (6) @(posedge mclk);
        rd_chk(REG_PRIM, 8'h02);
        chk({10'h0, pull_b_en, pull_a_en}, 12'h003);
        bw(REG_SRC, 8'h01);
        bw(REG_EDGE, 8'h04);
        bw(REG_EXTB, 8'h01);
        @(posedge mclk) pin_b_alt <= 1'b1;
        repeat (6) @(posedge mclk);
        rd_chk(REG_EXTB, 8'h11);
        bw(REG_EXTB, 8'h01);
        @(posedge mclk) pin_b_main <= 1'b1;
        repeat (6) @(posedge mclk);
        rd_chk(REG_EXTB, 8'h01);
        bw(REG_EXTB, 8'h00);
        bw(REG_PRIM, 8'h00);
        $display("edge tests done");
    endtask : t_edges

    task t_prio;
        bw(REG_SEC, 8'h05);
        pulse(8'h90, 1'b1);
        bw(REG_PRIM, 8'h01);
        see_take(vec(SRC_CONV));
        rd_chk(REG_SEC, 8'h45);
        rd_chk(REG_PRIM, 8'h00);
        do_ret;
        bw(REG_PRIM, 8'h01);
        see_take(vec(SRC_TICK0));
        do_ret;
        bw(REG_SEC, 8'h00);
        pulse(8'h20, 1'b1);
        pulse(8'h20, 1'b0);
        bw(REG_PRIM, 8'h01);
        see_take(12'hfff);
        bw(REG_PRIM, 8'h00);
        bw(REG_SEC, 8'h22);
        see_take(12'hfff);
        bw(REG_PRIM, 8'h01);
        see_take(vec(SRC_EEPROM));
        do_ret;
        $display("priority and mask tests done");
    endtask : t_prio

    task t_group;
        pulse(8'h08, 1'b1);
        rd_chk(REG_PRIM, 8'h20);
        bw(REG_PRIM, 8'h25);
        see_take(12'hfff);
        bw(REG_GRP0, 8'h22);
        see_take(vec(SRC_GRP0));
        rd_chk(REG_GRP0, 8'h22);
        rd_chk(REG_PRIM, 8'h04);
        do_ret;
        bw(REG_GRP0, 8'h00);
        bw(REG_GRP1, 8'h01);
        pulse(8'h01, 1'b1);
        bw(REG_PRIM, 8'h49);
        see_take(vec(SRC_GRP1));
        rd_chk(REG_GRP1, 8'h11);
        do_ret;
        $display("group tests done");
    endtask : t_group

    task t_stack;
        bw(REG_SEC, 8'h05);
        pulse(8'h10, 1'b1);
        bw(REG_PRIM, 8'h01);
        see_take(vec(SRC_CONV));
        pulse(8'h80, 1'b1);
        bw(REG_PRIM, 8'h01);
        see_take(12'hfff);
        chk({11'h0, irq_pending}, 12'h001);
        do_ret;
        see_take(vec(SRC_TICK0));
        do_ret;
        $display("stack tests done");
    endtask : t_stack

    // main sequence
    initial
    begin
        repeat (6) @(posedge mclk);
        nrst <= 1'b1;
        t_edges;
        t_prio;
        t_group;
        t_stack;
        close_out;
    end

    // watchdog against a hang
    initial
    begin
        repeat (5000) @(posedge mclk);
        failures++;
        close_out;
    end
endmodule : testbench
`default_nettype wire
